// ===== design/dsss_pkg.sv
package dsss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes, seeds and chip patterns
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 2;
  localparam logic [6:0] SCRAMBLER_SEED = 7'h6c;
  localparam logic [10:0] BARKER_WORD = 11'h712;
  localparam logic [3:0] BARKER_LAST_CHIP = 4'ha;
  localparam logic [3:0] CODE_LAST_CHIP = 4'h7;
  localparam logic [2:0] CCK_NEG_CHIP = 3'h6;
  localparam logic [1:0] PHASE_ZERO = 2'h0;
  localparam logic [1:0] PHASE_HALF_TURN = 2'h2;
  localparam logic [3:0] BITS_HEADER = 4'h1;
  localparam logic [7:0] WALSH_CODES [8] = '{8'h03, 8'h0c, 8'h30, 8'h3f, 8'h56, 8'h59, 8'h65, 8'h6a};

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    MODE_DBPSK, MODE_DQPSK, MODE_BMBOK, MODE_QMBOK, MODE_CCK55, MODE_CCK11
  } dsss_mode_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_SEND} dsss_state_t;

  typedef enum logic [1:0] {K_BARKER, K_MBOK, K_CCK} dsss_kind_t;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Phase index 0..3 (45, 135, 225, 315 deg) to sign bits, 1 means negative
  function automatic logic [1:0] ph2iq(input logic [1:0] ph);
    return {ph[1] ^ ph[0], ph[1]};
  endfunction

  // Dibit to counterclockwise phase step, optionally reversed
  function automatic logic [1:0] dq_delta(input logic d0, input logic d1, input logic rev);
    logic [1:0] dl;
    unique case ({d0, d1})
      2'b00: dl = 2'h0;
      2'b01: dl = 2'h1;
      2'b11: dl = 2'h2;
      2'b10: dl = 2'h3;
    endcase
    return rev ? 2'h0 - dl : dl;
  endfunction

  // Sign-magnitude nibble to signed modified orthogonal code
  function automatic logic [7:0] walsh_chips(input logic [3:0] nib);
    return WALSH_CODES[nib[2:0]] ^ {8{nib[3]}};
  endfunction

  function automatic logic [3:0] bits_per_sym(input dsss_mode_t m);
    unique case (m)
      MODE_DBPSK: return 4'h1;
      MODE_DQPSK: return 4'h2;
      MODE_BMBOK, MODE_CCK55: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction

endpackage

// ===== design/dsss_stream_if.sv
interface dsss_stream_if #(parameter int WIDTH = 2);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ===== design/dsss_fifo.sv
module dsss_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  // Streams
  dsss_stream_if.snk wr,
  dsss_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic room;
  } dsss_fifo_state_t;

  dsss_fifo_state_t s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign rd.valid = s_q.count != '0;
  assign rd.data = mem[s_q.rptr];
  assign wr.ready = s_q.room;

  always_comb begin
    s_d = s_q;
    push = wr.valid && s_q.room;
    pop = rd.valid && rd.ready;
    if (push) begin
      s_d.wptr = s_q.wptr + 1'b1;
    end
    if (pop) begin
      s_d.rptr = s_q.rptr + 1'b1;
    end
    s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
    s_d.room = s_d.count < (AW+1)'(DEPTH);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{wptr: '0, rptr: '0, count: '0, room: 1'b1};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clock) begin
    if (clk_en && push) begin
      mem[s_q.wptr] <= wr.data;
    end
  end
endmodule

// ===== design/dsss_scrambler.sv
module dsss_scrambler
  import dsss_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  // Control
  input wire logic init,
  input wire logic step,
  input wire logic [6:0] taps,
  // Data
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic [6:0] sr;
  } dsss_scr_state_t;

  dsss_scr_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    dout = din ^ (^(s_q.sr & taps));
    if (init) begin
      s_d.sr = SCRAMBLER_SEED;
    end else if (step) begin
      s_d.sr = {s_q.sr[5:0], dout};
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{sr: SCRAMBLER_SEED};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  scr_seed_load_a: assert property (@(posedge clock) disable iff (!resetn)
    (init && clk_en) |=> s_q.sr == SCRAMBLER_SEED) else $error("seed not loaded");
  scr_bypass_a: assert property (@(posedge clock) disable iff (!resetn)
    (taps == 7'h00) |-> dout == din) else $error("zero taps still scramble");
  scr_quotient_a: assert property (@(posedge clock) disable iff (!resetn)
    (step && !init && clk_en) |=> s_q.sr[0] == $past(dout) && s_q.sr[6:1] == $past(s_q.sr[5:0]))
    else $error("quotient not shifted in");
endmodule

// ===== design/dsss_tx_encoder.sv
module dsss_tx_encoder
  import dsss_pkg::*;
(
  // Clock, reset, chip-rate enable
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  // Transmit bit stream from the controller
  input wire logic transmit_path_enable,
  input wire logic tx_bit,
  input wire logic tx_header,
  input wire logic tx_valid,
  output logic tx_ready,
  // Configuration
  input wire dsss_pkg::dsss_mode_t data_mode,
  input wire logic [6:0] scrambler_tap_register,
  input wire logic tx_rotation_reverse,
  // Baseband chips
  output logic i_out,
  output logic q_out,
  output logic chip_valid,
  output logic tx_busy
);
  import dsss_pkg::*;

  typedef struct packed {
    dsss_state_t st;
    logic [3:0] chip;
    dsss_kind_t kind;
    logic hdr;
    logic qm;
    logic [1:0] ph;
    logic [1:0] p2;
    logic [1:0] p3;
    logic [1:0] p4;
    logic [7:0] ci;
    logic [7:0] cq;
    logic ref_bit;
    logic odd;
    logic [7:0] acc;
    logic [3:0] acnt;
    logic [3:0] need;
    logic ahdr;
    logic astart;
    logic i;
    logic q;
    logic cv;
    logic busy;
  } dsss_enc_state_t;

  dsss_enc_state_t s_q, s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Input buffer
  dsss_stream_if #(.WIDTH(FIFO_WIDTH)) in_if ();
  dsss_stream_if #(.WIDTH(FIFO_WIDTH)) rd_if ();

  assign in_if.data = {tx_header, tx_bit};
  assign in_if.valid = tx_valid;
  assign tx_ready = in_if.ready;

  dsss_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .clk_en(clk_en),
    .wr(in_if.snk),
    .rd(rd_if.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Scrambler
  logic scr_init, scr_step, scr_in, scr_out;

  dsss_scrambler u_scr (
    .clock(clock),
    .resetn(resetn),
    .clk_en(clk_en),
    .init(scr_init),
    .step(scr_step),
    .taps(scrambler_tap_register),
    .din(scr_in),
    .dout(scr_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Symbol assembly, encoding and chip generation
  logic gather, use_fifo, complete, last_chip, encode;
  logic [7:0] acc_n;
  logic [3:0] cnt_n, need_n;
  logic ahdr_n;
  logic [1:0] cph, nph;

  always_comb begin
    s_d = s_q;
    acc_n = s_q.acc;
    cnt_n = s_q.acnt;
    need_n = s_q.need;
    ahdr_n = s_q.ahdr;
    use_fifo = 1'b0;
    cph = PHASE_ZERO;
    nph = PHASE_ZERO;
    gather = (s_q.st != ST_IDLE) && (!s_q.astart || s_q.acnt < s_q.need);
    if (gather) begin
      if (!s_q.astart) begin
        use_fifo = rd_if.valid;
        ahdr_n = rd_if.valid && rd_if.data[1];
        need_n = ahdr_n ? BITS_HEADER : bits_per_sym(data_mode);
      end else begin
        use_fifo = rd_if.valid && (rd_if.data[1] == s_q.ahdr);
      end
      cnt_n = s_q.acnt + 4'h1;
    end
    // Missing bits become zero dummies so chips never stall
    scr_in = use_fifo && rd_if.data[0];
    if (gather) begin
      acc_n[s_q.acnt[2:0]] = scr_out;
    end
    scr_step = gather;
    scr_init = s_q.st == ST_IDLE;
    rd_if.ready = gather && use_fifo;
    complete = (s_q.astart || gather) && cnt_n == need_n;
    last_chip = s_q.chip == ((s_q.kind == K_BARKER) ? BARKER_LAST_CHIP : CODE_LAST_CHIP);

    s_d.acc = acc_n;
    s_d.acnt = cnt_n;
    s_d.need = need_n;
    s_d.ahdr = ahdr_n;
    s_d.astart = s_q.astart || gather;

    // Chip output from the symbol in flight
    s_d.cv = s_q.st == ST_SEND;
    s_d.i = 1'b0;
    s_d.q = 1'b0;
    if (s_q.st == ST_SEND) begin
      unique case (s_q.kind)
        K_BARKER: {s_d.i, s_d.q} = ph2iq(s_q.ph) ^ {2{BARKER_WORD[s_q.chip]}};
        K_MBOK: begin
          s_d.i = s_q.ci[s_q.chip[2:0]] ^ s_q.ref_bit;
          s_d.q = s_q.cq[s_q.chip[2:0]] ^ s_q.ref_bit;
        end
        K_CCK: begin
          cph = s_q.ph + (s_q.chip[0] ? PHASE_ZERO : s_q.p2) + (s_q.chip[1] ? PHASE_ZERO : s_q.p3)
              + (s_q.chip[2] ? PHASE_ZERO : s_q.p4)
              + ((s_q.chip[2:0] == CCK_NEG_CHIP) ? PHASE_HALF_TURN : PHASE_ZERO);
          {s_d.i, s_d.q} = ph2iq(cph);
        end
        default: {s_d.i, s_d.q} = 2'b00;
      endcase
    end

    unique case (s_q.st)
      ST_IDLE: begin
        s_d.ph = PHASE_ZERO;
        s_d.odd = 1'b0;
        if (transmit_path_enable && rd_if.valid) begin
          s_d.st = ST_FILL;
        end
      end
      ST_FILL, ST_SEND: begin
        if (s_q.st == ST_SEND && !last_chip) begin
          s_d.chip = s_q.chip + 4'h1;
        end else if (s_q.st == ST_SEND && !transmit_path_enable) begin
          s_d.st = ST_IDLE;
          s_d.acc = '0;
          s_d.acnt = '0;
          s_d.astart = 1'b0;
        end else if (complete) begin
          s_d.st = ST_SEND;
          s_d.chip = '0;
          s_d.hdr = ahdr_n;
          s_d.acc = '0;
          s_d.acnt = '0;
          s_d.astart = 1'b0;
          s_d.qm = 1'b0;
          if (ahdr_n) begin
            nph = s_q.ph + (acc_n[0] ? PHASE_HALF_TURN : PHASE_ZERO);
            s_d.kind = K_BARKER;
            s_d.ph = nph;
            s_d.ref_bit = nph[1];
            s_d.odd = 1'b0;
          end else begin
            unique case (data_mode)
              MODE_DBPSK: begin
                s_d.kind = K_BARKER;
                s_d.ph = s_q.ph + (acc_n[0] ? PHASE_HALF_TURN : PHASE_ZERO);
              end
              MODE_DQPSK: begin
                s_d.kind = K_BARKER;
                s_d.ph = s_q.ph + dq_delta(acc_n[0], acc_n[1], tx_rotation_reverse);
              end
              MODE_BMBOK: begin
                s_d.kind = K_MBOK;
                s_d.ci = walsh_chips(acc_n[3:0]);
                s_d.cq = walsh_chips(acc_n[3:0]);
              end
              MODE_QMBOK: begin
                s_d.kind = K_MBOK;
                s_d.qm = 1'b1;
                s_d.cq = walsh_chips(acc_n[3:0]);
                s_d.ci = walsh_chips(acc_n[7:4]);
              end
              MODE_CCK55: begin
                s_d.kind = K_CCK;
                s_d.ph = s_q.ph + dq_delta(acc_n[0], acc_n[1], tx_rotation_reverse)
                       + (s_q.odd ? PHASE_HALF_TURN : PHASE_ZERO);
                s_d.p2 = {acc_n[2], 1'b1};
                s_d.p3 = PHASE_ZERO;
                s_d.p4 = {acc_n[3], 1'b0};
                s_d.odd = !s_q.odd;
              end
              MODE_CCK11: begin
                s_d.kind = K_CCK;
                s_d.ph = s_q.ph + dq_delta(acc_n[0], acc_n[1], tx_rotation_reverse)
                       + (s_q.odd ? PHASE_HALF_TURN : PHASE_ZERO);
                s_d.p2 = {acc_n[2], acc_n[3]};
                s_d.p3 = {acc_n[4], acc_n[5]};
                s_d.p4 = {acc_n[6], acc_n[7]};
                s_d.odd = !s_q.odd;
              end
              default: s_d.kind = K_BARKER;
            endcase
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    s_d.busy = s_d.st != ST_IDLE;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign i_out = s_q.i;
  assign q_out = s_q.q;
  assign chip_valid = s_q.cv;
  assign tx_busy = s_q.busy;

  // Cycle in which a gathered symbol is encoded
  assign encode = complete && (s_q.st == ST_FILL || (s_q.st == ST_SEND && last_chip && transmit_path_enable));

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  hdr_iq_equal_a: assert property ((s_q.st == ST_SEND && s_q.hdr && clk_en) |=> i_out == q_out)
    else $error("header chip with I and Q apart");
  bmbok_iq_equal_a: assert property (
    (s_q.st == ST_SEND && s_q.kind == K_MBOK && !s_q.qm && clk_en) |=> i_out == q_out)
    else $error("binary code chip with I and Q apart");
  code_len_a: assert property ((s_q.st == ST_SEND && s_q.kind != K_BARKER) |-> s_q.chip <= CODE_LAST_CHIP)
    else $error("code symbol longer than eight chips");
  barker_chip_a: assert property (
    (s_q.st == ST_SEND && s_q.kind == K_BARKER && clk_en)
    |=> i_out == ($past(s_q.ph[1]) ^ $past(s_q.ph[0]) ^ BARKER_WORD[$past(s_q.chip)]))
    else $error("Barker chip wrong");
  cck_last_chip_a: assert property (
    (s_q.st == ST_SEND && s_q.kind == K_CCK && s_q.chip == CODE_LAST_CHIP && clk_en)
    |=> {i_out, q_out} == ph2iq($past(s_q.ph)))
    else $error("CCK reference chip wrong");
  hdr_parity_a: assert property ((s_q.st == ST_SEND && s_q.hdr) |-> !s_q.odd)
    else $error("symbol parity not restarted by header");
  mbok_ref_a: assert property (
    (s_q.st == ST_SEND && s_q.kind == K_MBOK && clk_en)
    |=> {i_out, q_out} == ({$past(s_q.ci[s_q.chip[2:0]]), $past(s_q.cq[s_q.chip[2:0]])} ^ {2{$past(s_q.ref_bit)}}))
    else $error("reference not applied to both rails");
  stop_idle_a: assert property (
    (s_q.st == ST_SEND && last_chip && !transmit_path_enable && clk_en) ##1 clk_en |=> !chip_valid)
    else $error("chips continue after enable drop");
  chip_run_a: assert property ((s_q.st == ST_SEND && !last_chip && clk_en) |=> s_q.st == ST_SEND)
    else $error("symbol cut short");
  busy_state_a: assert property (tx_busy == (s_q.st != ST_IDLE))
    else $error("busy flag disagrees with state");

  ////////////////////////////////////////////////////////////////////////////
  // Encode-time checks
  hdr_dbpsk_a: assert property ((encode && ahdr_n && clk_en) |=> s_q.kind == K_BARKER && s_q.hdr)
    else $error("header symbol not sent as Barker");
  hdr_ref_a: assert property ((encode && ahdr_n && clk_en) |=> s_q.ref_bit == s_q.ph[1])
    else $error("phase reference not kept from header");
  walsh_table_a: assert property (
    (encode && !ahdr_n && data_mode == MODE_BMBOK && clk_en)
    |=> s_q.ci == (WALSH_CODES[$past(acc_n[2:0])] ^ {8{$past(acc_n[3])}}))
    else $error("binary code word wrong");
  bmbok_same_a: assert property ((encode && !ahdr_n && data_mode == MODE_BMBOK && clk_en) |=> s_q.ci == s_q.cq)
    else $error("binary code differs between rails");
  qmbok_split_a: assert property (
    (encode && !ahdr_n && data_mode == MODE_QMBOK && clk_en)
    |=> s_q.cq == walsh_chips($past(acc_n[3:0])) && s_q.ci == walsh_chips($past(acc_n[7:4])))
    else $error("quaternary nibbles on wrong rails");
  dqpsk_hold_a: assert property (
    (encode && !ahdr_n && data_mode == MODE_DQPSK && !tx_rotation_reverse && acc_n[1:0] == 2'b00 && clk_en)
    |=> s_q.ph == $past(s_q.ph))
    else $error("dibit 00 changed phase");
  dqpsk_half_a: assert property (
    (encode && !ahdr_n && data_mode == MODE_DQPSK && acc_n[1:0] == 2'b11 && clk_en)
    |=> s_q.ph == $past(s_q.ph) + PHASE_HALF_TURN)
    else $error("dibit 11 not a half turn");
  cck_odd_a: assert property (
    (encode && !ahdr_n && (data_mode == MODE_CCK55 || data_mode == MODE_CCK11) && clk_en)
    |=> s_q.odd != $past(s_q.odd))
    else $error("symbol parity not toggled");
  cck55_phase_a: assert property (
    (encode && !ahdr_n && data_mode == MODE_CCK55 && clk_en)
    |=> s_q.p3 == PHASE_ZERO && s_q.p2[0] && !s_q.p4[0])
    else $error("5.5 phase terms wrong");
  cck11_phase_a: assert property (
    (encode && !ahdr_n && data_mode == MODE_CCK11 && clk_en)
    |=> s_q.p4 == {$past(acc_n[6]), $past(acc_n[7])})
    else $error("11 phase term wrong");

  cck_sent_c: cover property (s_q.st == ST_SEND && s_q.kind == K_CCK && last_chip);
  bmbok_sent_c: cover property (s_q.st == ST_SEND && s_q.kind == K_MBOK && !s_q.qm && last_chip);
  barker_data_c: cover property (s_q.st == ST_SEND && s_q.kind == K_BARKER && !s_q.hdr && last_chip);
  qmbok_sent_c: cover property (s_q.st == ST_SEND && s_q.qm && last_chip);
  packet_end_c: cover property (s_q.st == ST_SEND ##1 s_q.st == ST_IDLE);
endmodule

// ===== testbench/dsss_ctrl_model.sv
module dsss_ctrl_model (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  // Stream toward the encoder
  input wire logic tx_ready,
  output logic tx_bit,
  output logic tx_header,
  output logic tx_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] word_q [$];

  initial begin
    tx_bit = 1'b0;
    tx_header = 1'b0;
    tx_valid = 1'b0;
  end

  task automatic push(input logic hdr, input logic b);
    word_q.push_back({hdr, b});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Word held until taken; idle lines toggle so stale values never match
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_valid <= 1'b0;
    end else begin
      if (clk_en && tx_valid && tx_ready)
        void'(word_q.pop_front());
      if (!tx_valid || (clk_en && tx_ready)) begin
        tx_valid <= (word_q.size() != 0);
        tx_bit <= (word_q.size() != 0) ? word_q[0][0] : ~tx_bit;
        tx_header <= (word_q.size() != 0) ? word_q[0][1] : ~tx_header;
      end
    end
  end
endmodule

// ===== testbench/dsss_tx_scrambler_encoder_test.sv
module dsss_tx_scrambler_encoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dsss_pkg::*;

  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic transmit_path_enable = 1'b0;
  logic tx_bit, tx_header, tx_valid, tx_ready;
  dsss_mode_t data_mode = MODE_DBPSK;
  logic [6:0] scrambler_tap_register = 7'h00;
  logic tx_rotation_reverse = 1'b0;
  logic i_out, q_out, chip_valid, tx_busy;
  int errors = 0;
  int n_compared = 0;
  logic [1:0] got_q [$];
  logic [1:0] exp_q [$];
  logic [1:0] pkt_q [$];
  logic collecting = 1'b0;
  logic saw_full = 1'b0;
  logic gate = 1'b0;

  always #10 clock = ~clock;

  // Chip tick every other cycle while gated
  always @(posedge clock)
    clk_en <= !gate || !clk_en;

  dsss_tx_encoder dut_u (.clock(clock), .resetn(resetn), .clk_en(clk_en),
    .transmit_path_enable(transmit_path_enable), .tx_bit(tx_bit), .tx_header(tx_header),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .data_mode(data_mode),
    .scrambler_tap_register(scrambler_tap_register), .tx_rotation_reverse(tx_rotation_reverse),
    .i_out(i_out), .q_out(q_out), .chip_valid(chip_valid), .tx_busy(tx_busy));

  dsss_ctrl_model ctrl_u (.clock(clock), .resetn(resetn), .clk_en(clk_en), .tx_ready(tx_ready),
    .tx_bit(tx_bit), .tx_header(tx_header), .tx_valid(tx_valid));

  always @(posedge clock) begin
    if (collecting && chip_valid === 1'b1 && clk_en)
      got_q.push_back({i_out, q_out});
    if (collecting && tx_ready === 1'b0)
      saw_full <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic check_chip(input logic [1:0] act, input logic [1:0] exp);
    n_compared++;
    if (act !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic check_bit(input logic act, input logic exp);
    n_compared++;
    if (act !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic final_report;
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reference encoder
  function automatic int nbits(input dsss_mode_t m);
    case (m)
      MODE_DBPSK: return 1;
      MODE_DQPSK: return 2;
      MODE_BMBOK, MODE_CCK55: return 4;
      default: return 8;
    endcase
  endfunction

  function automatic logic [1:0] step(input logic d0, input logic d1, input logic rev);
    logic [1:0] s;
    s = (d0 ? 2'h2 : 2'h0) + ((d0 ^ d1) ? 2'h1 : 2'h0);
    return rev ? 2'h0 - s : s;
  endfunction

  task automatic emit_barker(input logic [1:0] ph);
    for (int k = 0; k < 11; k++)
      exp_q.push_back({ph[1] ^ ph[0], ph[1]} ^ {2{BARKER_WORD[k]}});
  endtask

  task automatic build_exp(input dsss_mode_t m, input logic [6:0] taps, input logic rev);
    logic [6:0] s;
    logic [1:0] ph, p, f2, f3, f4;
    logic [7:0] d, wq, wi;
    logic rb, sb;
    int n, sym;
    s = SCRAMBLER_SEED;
    ph = 2'h0;
    rb = 1'b0;
    n = 0;
    sym = 0;
    d = 8'h00;
    exp_q = {};
    for (int j = 0; j < pkt_q.size(); j++) begin
      sb = pkt_q[j][0] ^ (^(s & taps));
      s = {s[5:0], sb};
      if (pkt_q[j][1]) begin
        ph = ph + {sb, 1'b0};
        rb = ph[1];
        sym = 0;
        emit_barker(ph);
      end else begin
        d[n] = sb;
        n++;
        if (n == nbits(m)) begin
          n = 0;
          case (m)
            MODE_DBPSK: begin
              ph = ph + {d[0], 1'b0};
              emit_barker(ph);
            end
            MODE_DQPSK: begin
              ph = ph + step(d[0], d[1], rev);
              emit_barker(ph);
            end
            MODE_BMBOK, MODE_QMBOK: begin
              wq = WALSH_CODES[d[2:0]] ^ {8{d[3]}};
              wi = (m == MODE_QMBOK) ? WALSH_CODES[d[6:4]] ^ {8{d[7]}} : wq;
              for (int k = 0; k < 8; k++)
                exp_q.push_back({wi[k] ^ rb, wq[k] ^ rb});
            end
            default: begin
              ph = ph + step(d[0], d[1], rev) + (sym[0] ? 2'h2 : 2'h0);
              f2 = (m == MODE_CCK11) ? {d[2], d[3]} : {d[2], 1'b1};
              f3 = (m == MODE_CCK11) ? {d[4], d[5]} : 2'h0;
              f4 = (m == MODE_CCK11) ? {d[6], d[7]} : {d[3], 1'b0};
              for (int k = 0; k < 8; k++) begin
                p = ph + (k[0] ? 2'h0 : f2) + (k[1] ? 2'h0 : f3) + (k[2] ? 2'h0 : f4) + (k == 6 ? 2'h2 : 2'h0);
                exp_q.push_back({p[1] ^ p[0], p[1]});
              end
              sym++;
            end
          endcase
        end
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One packet: send, let three dummy symbols pass, shut down, compare
  task automatic run_pkt(input dsss_mode_t m, input logic [6:0] taps, input logic rev, input int nh, input int np);
    int c;
    int slen;
    pkt_q = {};
    for (c = 0; c < nh + np * nbits(m); c++)
      pkt_q.push_back({c < nh, 1'((c * 5 / 3) ^ (c >> 2))});
    build_exp(m, taps, rev);
    slen = (m == MODE_DBPSK || m == MODE_DQPSK) ? 11 : 8;
    got_q = {};
    @(posedge clock);
    saw_full <= 1'b0;
    data_mode <= m;
    scrambler_tap_register <= taps;
    tx_rotation_reverse <= rev;
    for (c = 0; c < pkt_q.size(); c++)
      ctrl_u.push(pkt_q[c][1], pkt_q[c][0]);
    transmit_path_enable <= 1'b1;
    collecting <= 1'b1;
    c = 0;
    while (got_q.size() < exp_q.size() + 3 * slen) begin
      @(posedge clock);
      c++;
      if (c > 20000) begin
        errors++;
        final_report();
      end
    end
    transmit_path_enable <= 1'b0;
    c = 0;
    while (tx_busy !== 1'b0 && c < 100) begin
      @(posedge clock);
      c++;
    end
    check_bit(tx_busy, 1'b0);
    repeat (2) @(posedge clock);
    check_bit(chip_valid, 1'b0);
    check_bit(tx_ready, 1'b1);
    collecting <= 1'b0;
    for (c = 0; c < exp_q.size(); c++)
      check_chip(got_q[c], exp_q[c]);
    repeat (8) @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_barker;
    run_pkt(MODE_DBPSK, 7'h00, 1'b0, 40, 8);
    check_bit(saw_full, 1'b1);
  endtask

  task automatic t_scramble;
    run_pkt(MODE_DBPSK, 7'h48, 1'b0, 12, 12);
    run_pkt(MODE_DBPSK, 7'h11, 1'b0, 4, 12);
  endtask

  task automatic t_dqpsk;
    run_pkt(MODE_DQPSK, 7'h48, 1'b0, 6, 12);
    run_pkt(MODE_DQPSK, 7'h48, 1'b1, 6, 12);
  endtask

  task automatic t_mbok;
    run_pkt(MODE_BMBOK, 7'h48, 1'b0, 6, 10);
    run_pkt(MODE_QMBOK, 7'h48, 1'b0, 7, 10);
  endtask

  task automatic t_cck;
    run_pkt(MODE_CCK55, 7'h48, 1'b0, 6, 10);
    run_pkt(MODE_CCK11, 7'h48, 1'b0, 5, 10);
    run_pkt(MODE_CCK11, 7'h48, 1'b1, 6, 8);
  endtask

  task automatic t_gated;
    gate <= 1'b1;
    run_pkt(MODE_QMBOK, 7'h48, 1'b0, 5, 6);
    gate <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  initial begin
    repeat (16) @(posedge clock);
    check_bit(tx_busy, 1'b0);
    check_bit(chip_valid, 1'b0);
    check_bit(tx_ready, 1'b1);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    t_barker();
    t_scramble();
    t_dqpsk();
    t_mbok();
    t_cck();
    t_gated();
    final_report();
  end
endmodule
